// File: hdl/ccpu_channel.sv
// Capture/compare/PWM channel with a classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Mode 0000 disables and resets channel logic
// [R2] Codes 0001, 0011, 1011 reserved, do nothing
// [R3] Mode 0010: match toggles pin, sets flag
// [R4] Mode 0100: capture every falling edge
// [R5] Mode 0101: capture every rising edge
// [R6] Mode 0110: capture every fourth rising edge
// [R7] Mode 1000: pin low, match forces high
// [R8] Mode 1001: pin high, match forces low
// [R9] Mode 1010: match only sets flag
// [R10] Top mode bits 11 select PWM
// [R11] Duty is ten bits, low two in control
// [R12] Duty double-buffered in high byte plus latch
// [R13] Clear pin when buffered duty equals timebase
// [R14] Duty above period keeps pin high
// [R15] Control bits 7:6 read zero, ignore writes
// [R16] One 16-bit register per channel
// [R17] Software sets period, duty, pin, timer, mode
// [R18] Prescale 1, 4, 16; period FFh full resolution
// [R19] Period match restarts timer, sets pin, loads buffer
// [R20] Capture copies timer and sets flag
module ccpu_channel (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Channel pin
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe_out,
    // Status
    output logic             irq_flag_out
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  ctrl;      // Duty bits and mode
        logic [15:0] value;     // Capture/compare/duty register
        logic [1:0]  dlat;      // Duty low-bit latch
        logic [7:0]  period;    // PWM period
        logic [2:0]  tbctl;     // Enable and prescale
        logic [7:0]  tmr;       // PWM timebase
        logic [5:0]  pre;       // Prescale and quarter counter
        logic [15:0] t16;       // Capture/compare timer
        logic        flag;      // Sticky channel flag
        logic        port_lat;  // Ordinary port output latch
        logic        pin_dir;   // 1 = input
        logic        pin_q;     // Previous pin sample
        logic [1:0]  ecnt;      // Rising edge counter
        logic        cmp_out;   // Compare output level
        logic        pwm_out;   // PWM output level
        logic        ack;       // Bus answer
        logic [31:0] rdat;      // Bus read data
        logic        pin_o;     // Registered pin level
        logic        pin_oe;    // Registered pin enable
    } ccpu_state_t;

    ccpu_state_t s;        // Current state
    ccpu_state_t next_s;   // Next state

    // ------------------------------------------------------------
    // Decoded helpers
    // ------------------------------------------------------------
    logic [3:0] mode;      // Active mode
    logic       is_pwm;    // PWM selected
    logic       is_cmp;    // Compare mode driving the pin
    logic       rise;      // Rising edge on pin
    logic       fall;      // Falling edge on pin
    logic       tick;      // Timebase advance
    logic [1:0] lo;        // Extension bits after this edge
    logic       cmp_hit;   // Compare match
    logic       req;       // New bus request
    logic       wr_go;     // Write committed with the answer
    logic [3:0] wmode;     // Mode being written

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_s  = s;
        mode    = s.ctrl[3:0];
        is_pwm  = (mode[3:2] == ccpu_pkg::MODE_PWM_TOP); // [R10]
        is_cmp  = (mode == ccpu_pkg::MODE_CMP_TGL) ||
                  (mode == ccpu_pkg::MODE_CMP_HI) ||
                  (mode == ccpu_pkg::MODE_CMP_LO);
        rise    = pin_in && !s.pin_q;
        fall    = !pin_in && s.pin_q;
        req     = wb_cyc_in && wb_stb_in && !s.ack;
        wr_go   = wb_cyc_in && wb_stb_in && wb_we_in && s.ack;
        wmode   = wb_dat_in[3:0];
        cmp_hit = (s.t16 == s.value);
        tick    = 1'b0;
        lo      = 2'h0;

        // Pin sample and free-running timer
        next_s.pin_q = pin_in;
        next_s.t16   = s.t16 + 16'h0001;

        // Bus answer drops the cycle after it rose
        next_s.ack = req;

        // Register writes land at the edge where the answer is seen
        if (wr_go && wb_sel_in[0])
        begin
            case (wb_adr_in)
                ccpu_pkg::OFS_CTRL:
                begin
                    next_s.ctrl = wb_dat_in[5:0]; // [R15]
                    if (wmode != mode)
                    begin
                        next_s.ecnt = 2'h0;
                    end
                end
                ccpu_pkg::OFS_VALUE:
                begin
                    next_s.value[7:0] = wb_dat_in[7:0]; // [R16]
                end
                ccpu_pkg::OFS_PERIOD:
                begin
                    next_s.period = wb_dat_in[7:0];
                end
                ccpu_pkg::OFS_TBCTL:
                begin
                    next_s.tbctl = wb_dat_in[2:0];
                end
                ccpu_pkg::OFS_STATUS:
                begin
                    // Write one to clear
                    if (wb_dat_in[0])
                    begin
                        next_s.flag = 1'b0;
                    end
                end
                ccpu_pkg::OFS_PORT:
                begin
                    next_s.port_lat = wb_dat_in[0];
                    next_s.pin_dir  = wb_dat_in[ccpu_pkg::PORT_DIR_BIT];
                end
                default:
                begin
                    next_s.ctrl = next_s.ctrl; // Timer (read-only) and unmapped: ignored
                end
            endcase
        end
        // High byte is the active duty buffer in PWM mode
        if (wr_go && wb_sel_in[1] &&
            wb_adr_in == ccpu_pkg::OFS_VALUE && !is_pwm)
        begin
            next_s.value[15:8] = wb_dat_in[15:8];
        end

        // Register reads
        if (req)
        begin
            case (wb_adr_in)
                ccpu_pkg::OFS_CTRL:   next_s.rdat = {26'h0, s.ctrl}; // [R15]
                ccpu_pkg::OFS_VALUE:  next_s.rdat = {16'h0, s.value};
                ccpu_pkg::OFS_PERIOD: next_s.rdat = {24'h0, s.period};
                ccpu_pkg::OFS_TBCTL:  next_s.rdat = {16'h0, s.tmr, 5'h0, s.tbctl};
                ccpu_pkg::OFS_STATUS: next_s.rdat = {31'h0, s.flag};
                ccpu_pkg::OFS_TIMER:  next_s.rdat = {16'h0, s.t16};
                ccpu_pkg::OFS_PORT:   next_s.rdat = {30'h0, s.pin_dir, s.port_lat};
                default:              next_s.rdat = 32'h0;
            endcase
        end

        // Timebase prescaler: quarter counter or prescale bits
        if (s.tbctl[ccpu_pkg::TB_EN_BIT])
        begin
            next_s.pre = s.pre + 6'h01;
            case (s.tbctl[1:0])
                ccpu_pkg::PRE_1:
                begin
                    tick = (s.pre[1:0] == 2'h3); // [R18]
                    lo   = next_s.pre[1:0];
                end
                ccpu_pkg::PRE_4:
                begin
                    tick = (s.pre[3:0] == 4'hF);
                    lo   = next_s.pre[3:2];
                end
                default:
                begin
                    tick = (s.pre == 6'h3F);
                    lo   = next_s.pre[5:4];
                end
            endcase
        end

        // PWM timebase and output
        if (tick)
        begin
            next_s.tmr = s.tmr + 8'h01;
        end
        if (is_pwm)
        begin
            if (tick && s.tmr == s.period)
            begin
                next_s.tmr         = 8'h00; // [R19]
                next_s.pwm_out     = 1'b1;
                next_s.value[15:8] = s.value[7:0]; // [R12]
                next_s.dlat        = s.ctrl[5:4];
            end
            // Clear as the count enters the duty; never if duty exceeds period
            if ({next_s.tmr, lo} == {next_s.value[15:8], next_s.dlat}) // [R11] [R13] [R14]
            begin
                next_s.pwm_out = 1'b0;
            end
        end
        else if (tick && s.tmr == s.period)
        begin
            next_s.tmr = 8'h00;
        end

        // Capture and compare events; setting wins over a clear
        case (mode)
            ccpu_pkg::MODE_OFF:
            begin
                next_s.cmp_out = 1'b0; // [R1]
                next_s.pwm_out = 1'b0;
                next_s.ecnt    = 2'h0;
                next_s.dlat    = 2'h0;
            end
            ccpu_pkg::MODE_CMP_TGL:
            begin
                if (cmp_hit)
                begin
                    next_s.cmp_out = !s.cmp_out; // [R3]
                    next_s.flag    = 1'b1;
                end
            end
            ccpu_pkg::MODE_CAP_FALL:
            begin
                if (fall)
                begin
                    next_s.value = s.t16; // [R4] [R20]
                    next_s.flag  = 1'b1;
                end
            end
            ccpu_pkg::MODE_CAP_RISE:
            begin
                if (rise)
                begin
                    next_s.value = s.t16; // [R5] [R20]
                    next_s.flag  = 1'b1;
                end
            end
            ccpu_pkg::MODE_CAP_R4:
            begin
                if (rise)
                begin
                    next_s.ecnt = s.ecnt + 2'h1; // [R6]
                    if (s.ecnt == ccpu_pkg::CAP_R4_LAST)
                    begin
                        next_s.value = s.t16; // [R20]
                        next_s.flag  = 1'b1;
                    end
                end
            end
            ccpu_pkg::MODE_CMP_HI:
            begin
                if (cmp_hit)
                begin
                    next_s.cmp_out = 1'b1; // [R7]
                    next_s.flag    = 1'b1;
                end
            end
            ccpu_pkg::MODE_CMP_LO:
            begin
                if (cmp_hit)
                begin
                    next_s.cmp_out = 1'b0; // [R8]
                    next_s.flag    = 1'b1;
                end
            end
            ccpu_pkg::MODE_CMP_SWI:
            begin
                if (cmp_hit)
                begin
                    next_s.flag = 1'b1; // [R9]
                end
            end
            default:
            begin
                next_s.ecnt = s.ecnt; // Reserved codes and PWM: no event [R2]
            end
        endcase

        // Initial level of set/clear compare modes, after the mode 0 clear
        if (wr_go && wb_sel_in[0] && wb_adr_in == ccpu_pkg::OFS_CTRL)
        begin
            if (wmode == ccpu_pkg::MODE_CMP_HI)
            begin
                next_s.cmp_out = 1'b0; // [R7]
            end
            else if (wmode == ccpu_pkg::MODE_CMP_LO)
            begin
                next_s.cmp_out = 1'b1; // [R8]
            end
        end

        // Pin mux: channel level or ordinary port latch
        if (is_pwm)
        begin
            next_s.pin_o = next_s.pwm_out;
        end
        else if (is_cmp)
        begin
            next_s.pin_o = next_s.cmp_out;
        end
        else
        begin
            next_s.pin_o = next_s.port_lat; // [R9]
        end
        next_s.pin_oe = !next_s.pin_dir;

        // Synchronous reset
        if (srst_in)
        begin
            next_s         = '0;
            next_s.pin_dir = ccpu_pkg::RST_PIN_DIR;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // Outputs straight from flops
    // ------------------------------------------------------------
    assign wb_dat_out   = s.rdat;
    assign wb_ack_out   = s.ack;
    assign pin_out      = s.pin_o;
    assign pin_oe_out   = s.pin_oe;
    assign irq_flag_out = s.flag;

endmodule : ccpu_channel

`default_nettype wire

// File: hdl/ccpu_pkg.sv
// Constants shared by the capture/compare/PWM channel
package ccpu_pkg;
    // ------------------------------------------------------------
    // Register byte offsets on the bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00; // channel_control
    localparam logic [7:0] OFS_VALUE  = 8'h04; // 16-bit channel register
    localparam logic [7:0] OFS_PERIOD = 8'h08; // period_reg_a
    localparam logic [7:0] OFS_TBCTL  = 8'h0C; // timebase_a_control
    localparam logic [7:0] OFS_STATUS = 8'h10; // channel_irq_flag
    localparam logic [7:0] OFS_TIMER  = 8'h14; // 16-bit capture/compare timer
    localparam logic [7:0] OFS_PORT   = 8'h18; // port latch and direction

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_DUTY_LSB = 4;  // duty_low_bits at 5:4
    localparam int TB_EN_BIT     = 2;  // timebase enable
    localparam int PORT_DIR_BIT  = 1;  // pin_direction_bit, 1 = input

    // ------------------------------------------------------------
    // Mode codes of channel_mode_select
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_OFF      = 4'h0;
    localparam logic [3:0] MODE_CMP_TGL  = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_R4   = 4'h6;
    localparam logic [3:0] MODE_CMP_HI   = 4'h8;
    localparam logic [3:0] MODE_CMP_LO   = 4'h9;
    localparam logic [3:0] MODE_CMP_SWI  = 4'hA;
    localparam logic [1:0] MODE_PWM_TOP  = 2'h3;

    // ------------------------------------------------------------
    // Prescale selections and counts
    // ------------------------------------------------------------
    localparam logic [1:0] PRE_1  = 2'h0;
    localparam logic [1:0] PRE_4  = 2'h1;
    localparam logic [1:0] CAP_R4_LAST = 2'h3; // fourth rising edge

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic       RST_PIN_DIR = 1'b1; // pin starts as input
endpackage : ccpu_pkg

// File: verif/ccpu_channel_monitor.sv
// Port assertions for the capture/compare/PWM channel
`timescale 1ns/1ps
`default_nettype none
module ccpu_channel_monitor (
    // Clock, reset and bus
    input wire logic        core_clk_in,
    input wire logic        srst_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    // Pin and flag
    input wire logic        pin_in,
    input wire logic        pin_out,
    input wire logic        pin_oe_out,
    input wire logic        irq_flag_out
);
    logic       wc;  // Control write taken
    logic       clr; // Flag clear taken
    logic [5:0] ctl; // Shadow of control bits
    assign wc  = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0]
                 && wb_adr_in == ccpu_pkg::OFS_CTRL;
    assign clr = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0]
                 && wb_dat_in[0] && wb_adr_in == ccpu_pkg::OFS_STATUS;
    // Follow control writes
    always_ff @(posedge core_clk_in)
        ctl <= srst_in ? 6'h00 : (wc ? wb_dat_in[5:0] : ctl);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    a_idle_no_flag: assert property (ctl[3:0] inside {4'h0, 4'h1, 4'h3, 4'hB}
        && $stable(ctl) && !irq_flag_out |=> !irq_flag_out) else $error("flag in idle mode");
    a_flag_hold: assert property (irq_flag_out && !clr |=> irq_flag_out)
        else $error("flag lost");
    a_ctrl_back: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h00
        |-> wb_dat_out[5:0] == ctl) else $error("control readback");
    a_ctrl_top: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h00
        |-> wb_dat_out[7:6] == 2'h0) else $error("control top bits");
    a_cap_rise: assert property (ctl[3:0] == 4'h5 && $rose(pin_in)
        |-> ##[1:3] irq_flag_out) else $error("rise not captured");
    a_cap_fall: assert property (ctl[3:0] == 4'h4 && $fell(pin_in)
        |-> ##[1:3] irq_flag_out) else $error("fall not captured");
    a_cmp_start_lo: assert property (wc && wb_dat_in[3:0] == 4'h8 |-> ##[2:3] !pin_out)
        else $error("pin not low");
    a_cmp_start_hi: assert property (wc && wb_dat_in[3:0] == 4'h9 |-> ##[2:3] pin_out)
        else $error("pin not high");
    c_read: cover property (wb_ack_out && !wb_we_in);
    c_flag: cover property ($rose(irq_flag_out));
    c_pwm: cover property (ctl[3:2] == 2'h3 && $fell(pin_out));
endmodule : ccpu_channel_monitor
`default_nettype wire

// File: verif/ccpu_pin_model.sv
// External circuit on the channel pin
`timescale 1ns/1ps
`default_nettype none
module ccpu_pin_model (
    // Design side
    input  wire logic pin_out,
    input  wire logic pin_oe_out,
    // Level wanted outside
    input  wire logic ext_lvl_in,
    // Level seen at the pin
    output logic      pin_lvl_out
);
    // Design drive wins, else the outside level
    assign pin_lvl_out = pin_oe_out ? pin_out : ext_lvl_in;
endmodule : ccpu_pin_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the capture/compare/PWM channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------------
    // Signals and instances
    // ----------------------
    logic        core_clk_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in, pin_in, ext_lvl;
    logic [7:0]  wb_adr_in;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out, rdat, seed;
    logic        wb_ack_out, pin_out, pin_oe_out, irq_flag_out;
    logic [31:0] rd_q[$];  // Expected read data
    logic        pin_q[$]; // Expected pin levels
    event        pin_ev;   // Pin sample point
    logic [15:0] t0, t1;   // Timer snapshots
    int          error_cnt, num_checks, n;
    logic [3:0]  rsv [3] = '{4'h1, 4'h3, 4'hB};
    logic [3:0]  cm [4] = '{4'h8, 4'h9, 4'h2, 4'hA};
    ccpu_channel dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_out(pin_oe_out), .irq_flag_out(irq_flag_out));
    ccpu_pin_model ext (.pin_out(pin_out), .pin_oe_out(pin_oe_out), .ext_lvl_in(ext_lvl),
        .pin_lvl_out(pin_in));
    // Clock source
    initial
    begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    // Read data against the oldest note
    always @(posedge core_clk_in)
        if (wb_ack_out === 1'b1 && wb_we_in === 1'b0 && rd_q.size() > 0)
            chk(wb_dat_out, rd_q.pop_front());
    // Pin level against the oldest note
    always @(pin_ev)
        chk({31'h0, pin_out}, {31'h0, pin_q.pop_front()});
    // ----------------------
    // Tasks
    // ----------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // One classic bus cycle, read data left in rdat
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int k;
        k = 0;
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        wb_sel_in <= s;
        do
        begin
            @(posedge core_clk_in);
            k++;
        end
        while (wb_ack_out !== 1'b1 && k < 16);
        if (k >= 16)
        begin
            error_cnt++;
            close_out();
        end
        rdat = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0, 4'hF);
    endtask : rd
    task automatic note_pin(input logic e);
        @(negedge core_clk_in);
        pin_q.push_back(e);
        ->pin_ev;
        @(posedge core_clk_in);
    endtask : note_pin
    // Wait for a PWM rise, then count high cycles over a window
    task automatic pwm_count(input int win, input int exp);
        int k;
        k = 0;
        do
        begin
            @(negedge core_clk_in);
            k++;
        end
        while (pin_out !== 1'b0 && k < 3000);
        while (pin_out !== 1'b1 && k < 3000)
        begin
            @(negedge core_clk_in);
            k++;
        end
        if (k >= 3000)
        begin
            error_cnt++;
            close_out();
        end
        n = 0;
        repeat (win)
        begin
            n += (pin_out === 1'b1);
            @(negedge core_clk_in);
        end
        chk(n, exp);
        @(posedge core_clk_in);
    endtask : pwm_count
    // ----------------------
    // Main sequence
    // ----------------------
    initial
    begin
        seed = 32'h000167D3;
        error_cnt = 0;
        num_checks = 0;
        {srst_in, wb_cyc_in, wb_stb_in, wb_we_in, ext_lvl} = 5'h10;
        {wb_adr_in, wb_sel_in, wb_dat_in} = 44'h0;
        repeat (5) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        rd(ccpu_pkg::OFS_CTRL, 32'h0);
        rd(ccpu_pkg::OFS_PORT, 32'h2);
        rd(8'h20, 32'h0);
        wr(ccpu_pkg::OFS_CTRL, 32'hE0);
        rd(ccpu_pkg::OFS_CTRL, 32'h20);
        t0 = 16'(rnd());
        wr(ccpu_pkg::OFS_VALUE, {16'h0, t0});
        wb(1'b1, ccpu_pkg::OFS_VALUE, {16'h0, ~t0}, 4'h2);
        rd(ccpu_pkg::OFS_VALUE, {16'h0, ~t0[15:8], t0[7:0]});
        foreach (rsv[i])
        begin
            wr(ccpu_pkg::OFS_CTRL, {28'h0, rsv[i]});
            ext_lvl <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            ext_lvl <= 1'b0;
            repeat (4) @(posedge core_clk_in);
            rd(ccpu_pkg::OFS_STATUS, 32'h0);
        end
        for (int m = 4; m < 6; m++)
        begin
            ext_lvl <= (m == 5);
            wr(ccpu_pkg::OFS_STATUS, 32'h1);
            wr(ccpu_pkg::OFS_CTRL, m);
            ext_lvl <= (m != 5);
            repeat (4) @(posedge core_clk_in);
            rd(ccpu_pkg::OFS_STATUS, 32'h0);
            wb(1'b0, ccpu_pkg::OFS_TIMER, 32'h0, 4'hF);
            t0 = rdat[15:0];
            ext_lvl <= (m == 5);
            repeat (4) @(posedge core_clk_in);
            wb(1'b0, ccpu_pkg::OFS_TIMER, 32'h0, 4'hF);
            t1 = rdat[15:0];
            rd(ccpu_pkg::OFS_STATUS, 32'h1);
            wb(1'b0, ccpu_pkg::OFS_VALUE, 32'h0, 4'hF);
            chk({31'h0, (rdat[15:0] - t0) < (t1 - t0)}, 32'h1);
        end
        ext_lvl <= 1'b0;
        wr(ccpu_pkg::OFS_CTRL, 32'h0);
        wr(ccpu_pkg::OFS_STATUS, 32'h1);
        wr(ccpu_pkg::OFS_CTRL, 32'h6);
        repeat (6)
        begin
            ext_lvl <= ~ext_lvl;
            repeat (3) @(posedge core_clk_in);
        end
        rd(ccpu_pkg::OFS_STATUS, 32'h0);
        ext_lvl <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        rd(ccpu_pkg::OFS_STATUS, 32'h1);
        wr(ccpu_pkg::OFS_PORT, 32'h1);
        chk({31'h0, pin_oe_out}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            wr(ccpu_pkg::OFS_CTRL, 32'h0);
            wr(ccpu_pkg::OFS_STATUS, 32'h1);
            wb(1'b0, ccpu_pkg::OFS_TIMER, 32'h0, 4'hF);
            wr(ccpu_pkg::OFS_VALUE, {16'h0, rdat[15:0] + 16'h28});
            wr(ccpu_pkg::OFS_CTRL, {28'h0, cm[i]});
            note_pin(1'(4'hA >> i));
            repeat (40) @(posedge core_clk_in);
            note_pin(1'(4'hD >> i));
            rd(ccpu_pkg::OFS_STATUS, 32'h1);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(ccpu_pkg::OFS_CTRL, 32'h0);
            wr(ccpu_pkg::OFS_PERIOD, 32'h3);
            wr(ccpu_pkg::OFS_VALUE, (i == 3) ? 32'h10 : 32'h1);
            wr(ccpu_pkg::OFS_CTRL, 32'h20);
            wr(ccpu_pkg::OFS_PORT, 32'h0);
            wr(ccpu_pkg::OFS_TBCTL, 32'h4 | (i % 3));
            wr(ccpu_pkg::OFS_CTRL, 32'h2C + i);
            pwm_count(64 << (2 * (i % 3)), (i == 3) ? 64 : 24 << (2 * i));
        end
        srst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        rd(ccpu_pkg::OFS_CTRL, 32'h0);
        close_out();
    end
endmodule : testbench
bind ccpu_channel ccpu_channel_monitor u_mon (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .irq_flag_out(irq_flag_out));
`default_nettype wire
